// file: common/rci_pkg.sv
// shared constants, indices and carrier types of the reclose logic
package rci_pkg;

    // time base
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned NS_PER_MS     = 1000000;
    localparam int unsigned TICKS_PER_MS  = NS_PER_MS / CLK_PERIOD_NS;

    // widths and counts
    localparam int unsigned CNT_W      = 32;
    localparam int unsigned DELAY_MS_W = 10;
    localparam int unsigned UV_N       = 3;
    localparam int unsigned TARGET_N   = 8;
    localparam int unsigned KEY_W      = 2;

    // fault-severity source positions
    localparam int unsigned SEV_OVERREACH    = 0;
    localparam int unsigned SEV_AIDED        = 1;
    localparam int unsigned SEV_ZONE_ONE     = 2;
    localparam int unsigned SEV_NEG_SEQ      = 3;
    localparam int unsigned SEV_TWO_OF_THREE = 4;
    localparam int unsigned SEV_N            = 5;

    // timer positions
    localparam int unsigned TMR_SECURITY = 0;
    localparam int unsigned TMR_DISCRIM  = 1;
    localparam int unsigned TMR_CIF      = 2;
    localparam int unsigned TIMER_N      = 3;

    typedef logic [SEV_N-1:0] rci_sev_t;

    // contact converter inputs in use
    typedef struct packed {
        logic permissiveReceiver;
        logic channelTwo;
        logic transferTrip;
        logic threePoleArm;
        logic timerBypass;
        logic tripAllowReclose;
        logic tripLockout;
        logic outputBlock;
        logic targetReset;
        logic selectorBlockEnable;
    } rci_cc_s;

    // registered outputs toward relays, channel and scheme logic
    typedef struct packed {
        logic             inhibitReclose;
        logic             lockoutReclose;
        logic             recloseInitiate;
        logic             breakerFailureInitiate;
        logic             tripThreePole;
        logic             tripSinglePole;
        logic [KEY_W-1:0] permissiveKeyOutput;
        logic             inServiceIndicator;
        logic             threePoleArmed;
        logic             permissiveReceive;
        logic             channelTwoReceive;
        logic             overreachThreeSelect;
        logic             weakInfeedUvSelect;
        logic             closeIntoFaultEnable;
    } rci_out_s;

    typedef struct packed {
        logic [SEV_N-1:0]    sealed;
        logic [TARGET_N-1:0] target;
        rci_out_s            outs;
    } rci_state_s;

    typedef struct packed {
        logic [CNT_W-1:0] count;
        logic             expired;
    } rci_timer_s;

    // values after reset
    localparam rci_state_s STATE_RESET = '0;
    localparam rci_timer_s TIMER_RESET = '0;

endpackage : rci_pkg

// file: rtl/rci_delay_timer.sv
// pickup delay timer counting sys_clk cycles while its input stands
`timescale 1ns/100ps

module rci_delay_timer (
    // clock and reset
    input  wire logic                      sys_clk,
    input  wire logic                      rstn,
    // timing
    input  wire logic                      run,
    input  wire logic [rci_pkg::CNT_W-1:0] terminal,
    output logic                           expired
);

    rci_pkg::rci_timer_s st_q;
    rci_pkg::rci_timer_s st_d;

    always_comb begin
        st_d = st_q;
        if (!run) begin
            // any drop of the input restarts the delay from zero
            st_d = rci_pkg::TIMER_RESET;
        end else if (!st_q.expired) begin
            st_d.count   = st_q.count + 1'b1;
            // a zero setting behaves as one cycle
            st_d.expired = (st_d.count >= terminal);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            st_q <= rci_pkg::TIMER_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    assign expired = st_q.expired;

endmodule : rci_delay_timer

// file: rtl/rci_reclose_logic.sv
// reclose inhibit, lockout, contact converter and keying logic
`timescale 1ns/100ps

// Functional notes
// - inhibit reclose on any enabled severity source or timed transfer trip
// - lockout on long transfer timer, zone timers, overcurrent, external trip, out-of-step trip
// - each enabled severity source that operates stays sealed while any undervoltage output stands
// - inhibit releases once undervoltage drops and no severity source or timed transfer trip is live
// - transfer trip term never enters the undervoltage seal-in
// - transfer term comes from security timer, only while remote signal persists
// - prolonged transfer trip times out the long timer and locks out
// - negative-sequence and two-of-three sources each have an enable switch
// - first converter is permissive receiver, second is channel two receiver
// - third converter is transfer trip channel input; partner idles it low
// - fifth converter arms three-pole tripping for every fault type
// - sixth converter bypasses close-into-fault timer through its gate
// - seventh converter trips three-pole without blocking initiate or lockout
// - eighth converter trips, locks out, blocks initiate when switch set
// - ninth converter blocks trip, failure initiate, initiate, keying, in-service
// - tenth converter clears all latched target lamps
// - with twelfth converter, phase selectors block overreach three-pole select
// - with twelfth converter, phase selectors block weak-infeed undervoltage select
// - pair of normally open keying outputs drive permissive transmitter
module rci_reclose_logic #(
    parameter int unsigned TICKS_PER_MS = rci_pkg::TICKS_PER_MS
) (
    // clock and reset
    input  wire logic                                sys_clk,
    input  wire logic                                rstn,
    // contact converters
    input  wire rci_pkg::rci_cc_s                    cc,
    // fault-severity sources and their enables
    input  wire rci_pkg::rci_sev_t                   severity,
    input  wire rci_pkg::rci_sev_t                   inhibitSourceSwitch,
    input  wire logic [rci_pkg::UV_N-1:0]            underVoltage,
    // lockout sources
    input  wire logic                                zoneTwoTimerOut,
    input  wire logic                                zoneThreeTimerOut,
    input  wire logic                                timeOvercurrentTrip,
    input  wire logic                                outOfStepBlock,
    // scheme requests
    input  wire logic                                schemeTrip,
    input  wire logic                                pilotKeyReq,
    input  wire logic                                overreachThreeReq,
    input  wire logic                                weakInfeedUvReq,
    input  wire logic                                phaseSelectorAny,
    input  wire logic                                lineEnergizing,
    input  wire logic                                closeIntoFaultReq,
    input  wire logic [rci_pkg::TARGET_N-1:0]        targetEvent,
    // settings
    input  wire logic                                initiateBlockSwitch,
    input  wire logic [rci_pkg::DELAY_MS_W-1:0]      securityDelayMs,
    input  wire logic [rci_pkg::DELAY_MS_W-1:0]      discrimDelayMs,
    input  wire logic [rci_pkg::DELAY_MS_W-1:0]      closeIntoFaultMs,
    // outputs
    output rci_pkg::rci_out_s                        outs,
    output logic [rci_pkg::TARGET_N-1:0]             targetLamp
);

    // converts a millisecond setting into a terminal count of cycles
    function automatic logic [rci_pkg::CNT_W-1:0] msToTicks(
        input logic [rci_pkg::DELAY_MS_W-1:0] ms
    );
        logic [63:0] prod;
        prod = 64'(ms) * 64'(TICKS_PER_MS);
        return prod[rci_pkg::CNT_W-1:0];
    endfunction : msToTicks

    rci_pkg::rci_state_s st_q;
    rci_pkg::rci_state_s st_d;

    // timer inputs and outputs
    logic [rci_pkg::TIMER_N-1:0] timerRun;
    logic [rci_pkg::TIMER_N-1:0] timerDone;
    logic [rci_pkg::CNT_W-1:0]   timerTerm [rci_pkg::TIMER_N];

    // combinational terms
    logic              uvAny;
    rci_pkg::rci_sev_t sevLive;
    logic              transferInhibit;
    logic              transferTrip;
    logic              cifGate;
    logic              cifTrip;
    logic              threeSelect;
    logic              wiSelect;
    logic              selectorBlock;
    logic              forceThree;
    logic              anyTrip;
    logic              lockoutNow;
    logic              initiateBlocked;
    logic              outputsAllowed;

    // timer wiring
    always_comb begin
        // the long timer watches the raw channel, so it sees the whole duration
        timerRun[rci_pkg::TMR_SECURITY]  = cc.transferTrip;
        timerRun[rci_pkg::TMR_DISCRIM]   = cc.transferTrip;
        timerRun[rci_pkg::TMR_CIF]       = lineEnergizing;
        timerTerm[rci_pkg::TMR_SECURITY] = msToTicks(securityDelayMs);
        timerTerm[rci_pkg::TMR_DISCRIM]  = msToTicks(discrimDelayMs);
        timerTerm[rci_pkg::TMR_CIF]      = msToTicks(closeIntoFaultMs);
    end

    generate
        for (genvar t = 0; t < rci_pkg::TIMER_N; t++) begin : g_timer
            rci_delay_timer u_timer (
                .sys_clk  (sys_clk),
                .rstn     (rstn),
                .run      (timerRun[t]),
                .terminal (timerTerm[t]),
                .expired  (timerDone[t])
            );
        end
    endgenerate

    // severity and transfer terms
    always_comb begin
        uvAny   = |underVoltage;
        // every source has its own switch, the two weak ones included
        sevLive = severity & inhibitSourceSwitch;
        // security timer output drops as soon as the remote signal goes
        transferInhibit = timerDone[rci_pkg::TMR_SECURITY];
        transferTrip    = timerDone[rci_pkg::TMR_SECURITY];
    end

    // close-into-fault path
    always_comb begin
        cifGate = timerDone[rci_pkg::TMR_CIF];
        if (cc.timerBypass) begin
            // bypass removes the delay; closing into a fault trips at once
            cifGate = lineEnergizing;
        end
        cifTrip = closeIntoFaultReq & cifGate;
    end

    // phase selection supervision
    always_comb begin
        selectorBlock = cc.selectorBlockEnable & phaseSelectorAny;
        threeSelect   = overreachThreeReq & ~selectorBlock;
        wiSelect      = weakInfeedUvReq & ~selectorBlock;
    end

    // trip bus and pole selection
    always_comb begin
        anyTrip = schemeTrip;
        anyTrip = anyTrip | cc.tripAllowReclose;
        anyTrip = anyTrip | cc.tripLockout;
        anyTrip = anyTrip | cifTrip;
        anyTrip = anyTrip | transferTrip;
        forceThree = cc.threePoleArm;
        forceThree = forceThree | threeSelect;
        forceThree = forceThree | cc.tripAllowReclose;
        forceThree = forceThree | cc.tripLockout;
        forceThree = forceThree | cifTrip;
        forceThree = forceThree | transferTrip;
    end

    // lockout and initiate blocking
    always_comb begin
        lockoutNow = timerDone[rci_pkg::TMR_DISCRIM];
        lockoutNow = lockoutNow | zoneTwoTimerOut;
        lockoutNow = lockoutNow | zoneThreeTimerOut;
        lockoutNow = lockoutNow | timeOvercurrentTrip;
        lockoutNow = lockoutNow | cc.tripLockout;
        lockoutNow = lockoutNow | (outOfStepBlock & anyTrip);
        // the allow-reclose converter is deliberately absent above
        initiateBlocked = cc.tripLockout & initiateBlockSwitch;
        // lockout still reaches the reclosing control while outputs are blocked
        outputsAllowed  = ~cc.outputBlock;
    end

    // next state
    always_comb begin
        st_d = st_q;

        // seal-in: a source stays latched while any undervoltage stands
        st_d.sealed = sevLive | (st_q.sealed & {rci_pkg::SEV_N{uvAny}});

        // a new event wins over a reset in the same cycle
        st_d.target = targetEvent | (st_q.target & ~{rci_pkg::TARGET_N{cc.targetReset}});

        // transfer term is added outside the seal-in
        st_d.outs.inhibitReclose = |sevLive | (|st_q.sealed) | transferInhibit;

        st_d.outs.lockoutReclose = lockoutNow;

        st_d.outs.tripThreePole = anyTrip & forceThree & outputsAllowed;

        st_d.outs.tripSinglePole = anyTrip & ~forceThree & outputsAllowed;

        st_d.outs.breakerFailureInitiate = anyTrip & outputsAllowed;

        st_d.outs.recloseInitiate = anyTrip & ~initiateBlocked & outputsAllowed;

        // both contacts of the pair follow the same key request
        st_d.outs.permissiveKeyOutput = {rci_pkg::KEY_W{pilotKeyReq & outputsAllowed}};

        st_d.outs.inServiceIndicator = outputsAllowed;

        st_d.outs.threePoleArmed = cc.threePoleArm;

        st_d.outs.permissiveReceive = cc.permissiveReceiver;

        st_d.outs.channelTwoReceive = cc.channelTwo;

        st_d.outs.overreachThreeSelect = threeSelect;

        st_d.outs.weakInfeedUvSelect = wiSelect;

        st_d.outs.closeIntoFaultEnable = cifGate;
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            st_q <= rci_pkg::STATE_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    assign outs       = st_q.outs;
    assign targetLamp = st_q.target;

endmodule : rci_reclose_logic

// file: testbench/rci_reclose_logic_props.sv
// concurrent checks on the reclose logic ports
`timescale 1ns/100ps

module rci_reclose_logic_props (
    // clock and reset
    input wire logic                         sys_clk,
    input wire logic                         rstn,
    // causes
    input wire rci_pkg::rci_cc_s             cc,
    input wire rci_pkg::rci_sev_t            severity,
    input wire rci_pkg::rci_sev_t            inhibitSourceSwitch,
    input wire logic [rci_pkg::UV_N-1:0]     underVoltage,
    input wire logic                         schemeTrip,
    input wire logic                         pilotKeyReq,
    input wire logic                         phaseSelectorAny,
    input wire logic                         lineEnergizing,
    input wire logic [rci_pkg::TARGET_N-1:0] targetEvent,
    // effects
    input wire rci_pkg::rci_out_s            outs,
    input wire logic [rci_pkg::TARGET_N-1:0] targetLamp
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // lockout is never blocked, the trip itself is blocked by the output block converter
    a_lockout_trip: assert property ($past(rstn) && $past(cc.tripLockout)
        |-> outs.lockoutReclose && (outs.tripThreePole || $past(cc.outputBlock)))
        else $error("external trip without lockout");
    // the lockout converter may block initiate on its own, so it is kept out here
    a_allow_trip: assert property ($past(rstn)
        && $past(cc.tripAllowReclose && !cc.outputBlock && !cc.tripLockout)
        |-> outs.tripThreePole && outs.recloseInitiate)
        else $error("trip allowing reclose wrong");
    a_block_all: assert property ($past(rstn) && $past(cc.outputBlock) |-> !(outs.tripThreePole || outs.tripSinglePole || outs.recloseInitiate || outs.breakerFailureInitiate || outs.inServiceIndicator || |outs.permissiveKeyOutput))
        else $error("output not blocked");
    a_arm_three: assert property ($past(rstn) && $past(cc.threePoleArm && schemeTrip && !cc.outputBlock) |-> outs.tripThreePole && !outs.tripSinglePole)
        else $error("armed trip not three pole");
    a_recv_map: assert property ($past(rstn) |-> {outs.permissiveReceive, outs.channelTwoReceive} == $past({cc.permissiveReceiver, cc.channelTwo}))
        else $error("receiver mapping wrong");
    a_key_pair: assert property ($past(rstn) |-> outs.permissiveKeyOutput == {2{$past(pilotKeyReq && !cc.outputBlock)}})
        else $error("keying pair wrong");
    // two cycles on, only the sealed bit can still hold the inhibit
    a_seal_uv: assert property ($past(rstn) && |(severity & inhibitSourceSwitch)
        ##1 |underVoltage |-> ##2 outs.inhibitReclose)
        else $error("seal-in lost");
    // sealed bits lag one cycle, so two quiet cycles are needed before release
    a_release_uv: assert property ($past(rstn) && $past(underVoltage) == '0
        && $past(underVoltage, 2) == '0 && $past(severity & inhibitSourceSwitch) == '0
        && $past(severity & inhibitSourceSwitch, 2) == '0
        && !$past(cc.transferTrip) && !$past(cc.transferTrip, 2) |-> !outs.inhibitReclose)
        else $error("inhibit not released");
    a_select_blk: assert property ($past(rstn) && $past(cc.selectorBlockEnable && phaseSelectorAny) |-> !outs.overreachThreeSelect && !outs.weakInfeedUvSelect)
        else $error("selection not blocked");
    a_target_clr: assert property ($past(rstn) && $past(cc.targetReset) && $past(targetEvent) == '0 |-> targetLamp == '0)
        else $error("targets not cleared");
    a_cif_bypass: assert property ($past(rstn) && $past(cc.timerBypass) |-> outs.closeIntoFaultEnable == $past(lineEnergizing))
        else $error("timer bypass wrong");
endmodule : rci_reclose_logic_props

bind rci_reclose_logic rci_reclose_logic_props u_props (.sys_clk, .rstn, .cc, .severity,
    .inhibitSourceSwitch, .underVoltage, .schemeTrip, .pilotKeyReq, .phaseSelectorAny,
    .lineEnergizing, .targetEvent, .outs, .targetLamp);

// file: testbench/rci_far_side.sv
// channel receivers and arming contacts seen from the far side
`timescale 1ns/100ps

module rci_far_side (
    // clock
    input  wire logic        sys_clk,
    // commands
    input  wire logic [15:0] ttCycles,
    input  wire logic        ttGo,
    input  wire logic        threePoleOnly,
    input  wire logic [1:0]  rxLevels,
    // converter levels
    output rci_pkg::rci_cc_s ccFar
);
    logic [15:0] left = '0;
    // changes land just after the edge, never racing the sampling edge
    always @(posedge sys_clk) begin
        if (ttGo) begin
            left <= #1 ttCycles;
        end else if (left != 16'h0) begin
            left <= #1 left - 16'h1;
        end
    end
    always_comb begin
        ccFar                    = '0;
        ccFar.transferTrip       = (left != 16'h0);
        ccFar.threePoleArm       = threePoleOnly;
        ccFar.permissiveReceiver = rxLevels[0];
        ccFar.channelTwo         = rxLevels[1];
    end
endmodule : rci_far_side

// file: testbench/rci_reclose_logic_bench.sv
// self-checking bench of the reclose logic
`timescale 1ns/100ps

`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("ERROR %s expected %0h seen %0h", nm, exp, got); end end

module rci_reclose_logic_bench;
    logic              sys_clk = 1'b0;
    logic              rstn    = 1'b0;
    rci_pkg::rci_cc_s  ccDrv   = '0;
    rci_pkg::rci_cc_s  ccFar;
    rci_pkg::rci_sev_t sev     = '0;
    rci_pkg::rci_sev_t sevEn   = '1;
    logic [2:0]        uv      = '0;
    logic [3:0]        lockSrc = '0;
    logic [6:0]        req     = '0; // trip key orSel wiSel selAny energize cif
    logic [7:0]        tEv     = '0;
    logic              ibSw    = 1'b0;
    logic [15:0]       ttLen   = '0;
    logic              ttGo    = 1'b0;
    logic              tpOnly  = 1'b0;
    logic [1:0]        rx      = '0;
    rci_pkg::rci_out_s outs;
    logic [7:0]        lamp;
    logic [7:0]        got;
    int                n_mismatch  = 0;
    int                check_count = 0;
    int                cyc         = 0;

    always #5 sys_clk = ~sys_clk;
    rci_far_side u_far (.sys_clk(sys_clk), .ttCycles(ttLen), .ttGo(ttGo),
        .threePoleOnly(tpOnly), .rxLevels(rx), .ccFar(ccFar));
    // short tick keeps every timer a few cycles long
    rci_reclose_logic #(.TICKS_PER_MS(2)) DUT (.sys_clk(sys_clk), .rstn(rstn),
        .cc(ccDrv | ccFar), .severity(sev), .inhibitSourceSwitch(sevEn), .underVoltage(uv),
        .zoneTwoTimerOut(lockSrc[0]), .zoneThreeTimerOut(lockSrc[1]),
        .timeOvercurrentTrip(lockSrc[2]), .outOfStepBlock(lockSrc[3]), .schemeTrip(req[0]),
        .pilotKeyReq(req[1]), .overreachThreeReq(req[2]), .weakInfeedUvReq(req[3]),
        .phaseSelectorAny(req[4]), .lineEnergizing(req[5]), .closeIntoFaultReq(req[6]),
        .targetEvent(tEv), .initiateBlockSwitch(ibSw), .securityDelayMs(10'h2),
        .discrimDelayMs(10'h5), .closeIntoFaultMs(10'h3), .outs(outs), .targetLamp(lamp));

    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : step

    task automatic t_trips();
        for (int s = 0; s < 2; s++) begin
            ibSw              = s[0];
            ccDrv.tripLockout = 1'b1;
            step(1);
            `CHK("lockout", 1'b1, outs.lockoutReclose)
            `CHK("initiate", ~s[0], outs.recloseInitiate)
            ccDrv = '0;
            ccDrv.tripAllowReclose = 1'b1;
            step(1);
            `CHK("allow", 3'b011, {outs.lockoutReclose, outs.tripThreePole, outs.recloseInitiate})
            ccDrv = '0;
        end
        ibSw = 1'b0;
    endtask : t_trips

    task automatic t_block();
        ccDrv.outputBlock = 1'b1;
        ccDrv.tripLockout = 1'b1;
        req               = 7'h03;
        for (int s = 0; s < 2; s++) begin
            step(1);
            got = {outs.lockoutReclose, outs.tripThreePole, outs.tripSinglePole, outs.recloseInitiate,
                outs.breakerFailureInitiate, outs.permissiveKeyOutput, outs.inServiceIndicator};
            `CHK("block outputs", (s == 0) ? 8'h80 : 8'hdf, got)
            ccDrv.outputBlock = 1'b0;
        end
        ccDrv   = '0;
        lockSrc = 4'h0;
        for (int i = 0; i < 4; i++) begin
            lockSrc = 4'h1 << i;
            step(1);
            `CHK("lockout source", 1'b1, outs.lockoutReclose)
        end
        req = '0;
        step(1);
        `CHK("out-of-step alone", 1'b0, outs.lockoutReclose)
        lockSrc = '0;
    endtask : t_block

    task automatic t_seal();
        for (int i = 0; i < 10; i++) begin
            sevEn = (i < 5) ? 5'h1f : ~(5'h1 << (i - 5));
            sev   = 5'h1 << (i % 5);
            uv    = 3'h1 << (i % 3);
            step(1);
            sev = '0;
            step(2);
            `CHK("sealed inhibit", i < 5, outs.inhibitReclose)
            uv = '0;
            // the sealed bit clears one edge before the inhibit register follows
            step(2);
            `CHK("released inhibit", 1'b0, outs.inhibitReclose)
        end
        sevEn = '1;
    endtask : t_seal

    task automatic t_transfer();
        uv    = 3'h4;
        ttLen = 16'd20;
        ttGo  = 1'b1;
        step(1);
        ttGo = 1'b0;
        step(4);
        `CHK("inhibit early", 1'b0, outs.inhibitReclose)
        step(1);
        `CHK("inhibit timed", 2'b11, {outs.inhibitReclose, outs.tripThreePole})
        step(5);
        `CHK("lockout early", 1'b0, outs.lockoutReclose)
        step(1);
        `CHK("lockout timed", 1'b1, outs.lockoutReclose)
        step(12);
        `CHK("transfer gone", 2'b00, {outs.inhibitReclose, outs.lockoutReclose})
        uv    = '0;
        ttLen = 16'd6;
        ttGo  = 1'b1;
        step(1);
        ttGo = 1'b0;
        step(12);
        `CHK("short transfer", 1'b0, outs.lockoutReclose)
    endtask : t_transfer

    task automatic t_misc();
        tEv = 8'h5a;
        step(1);
        `CHK("target set", 8'h5a, lamp)
        tEv               = '0;
        ccDrv.targetReset = 1'b1;
        step(1);
        `CHK("target clear", 8'h00, lamp)
        tEv = 8'h81;
        step(1);
        `CHK("target wins", 8'h81, lamp)
        tEv   = '0;
        ccDrv = '0;
        req   = 7'h1c;
        for (int s = 0; s < 2; s++) begin
            ccDrv.selectorBlockEnable = s[0];
            step(1);
            `CHK("selection", {2{~s[0]}}, {outs.overreachThreeSelect, outs.weakInfeedUvSelect})
        end
        ccDrv = '0;
        req   = '0;
        for (int s = 1; s < 3; s++) begin
            rx = s[1:0];
            step(1);
            `CHK("receivers", {s[0], s[1]}, {outs.permissiveReceive, outs.channelTwoReceive})
        end
        ccDrv.timerBypass = 1'b1;
        req[5]            = 1'b1;
        step(1);
        `CHK("bypass", 1'b1, outs.closeIntoFaultEnable)
        ccDrv.timerBypass = 1'b0;
        step(5);
        `CHK("cif early", 1'b0, outs.closeIntoFaultEnable)
        step(1);
        `CHK("cif timed", 1'b1, outs.closeIntoFaultEnable)
        req[6] = 1'b1;
        step(1);
        `CHK("cif trip", 2'b10, {outs.tripThreePole, outs.tripSinglePole})
        req = 7'h01;
        for (int s = 0; s < 2; s++) begin
            tpOnly = s[0];
            step(1);
            `CHK("pole count", s[0] ? 2'b10 : 2'b01, {outs.tripThreePole, outs.tripSinglePole})
            `CHK("armed", s[0], outs.threePoleArmed)
        end
    endtask : t_misc

    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : complete_run

    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 2000) begin
            n_mismatch++;
            complete_run();
        end
    end

    initial begin
        step(2);
        `CHK("reset outputs", '0, outs)
        rstn = 1'b1;
        step(1);
        `CHK("in service", 1'b1, outs.inServiceIndicator)
        t_trips();
        t_block();
        t_seal();
        t_transfer();
        t_misc();
        complete_run();
    end
endmodule : rci_reclose_logic_bench
